// ===== core/src_pkg.sv
// Function
// - All reset sources merge into one master system reset output.
// - Power-on, pin, software, watchdog, brown-out and mismatch each assert master reset.
// - Configuration mismatch sets cause flag bit 9; resets to zero.
// - Bit 8 is read/write regulator standby enable, reset zero, on in Sleep.
// - External master-clear pin reset sets flag bit 7; resets to zero.
// - Software reset sets cause flag bit 6; resets to zero.
// - Watchdog time-out sets flag bit 4; resets to zero.
// - Wake from Sleep sets flag bit 3; resets to zero.
// - Wake from Idle sets flag bit 2; resets to zero.
// - Brown-out sets flag bit 1; it is one after power-on.
// - Power-on sets flag bit 0; it is one after power-on.
// - Brown-out and power-on flags hold until software writes zero.
// - Cause register bits 31..10 and bit 5 read as zero.
// - Writing one to trigger bit 0 starts software reset, self-clearing; zero ignored.
// - Trigger write accepted only after the system unlock sequence completed.
// - Trigger register bits 31..1 read as zero.
package src_pkg;
  localparam int          SRC_ADDR_W     = 4;
  localparam int          SRC_DATA_W     = 32;
  localparam int          SRC_STRB_W     = 4;
  localparam int          SRC_CAUSE_W    = 10;
  localparam int          SRC_IRQ_W      = 5;
  localparam int          SRC_SYNC_W     = 4;

  // Register byte offsets
  localparam logic [3:0]  ADDR_CAUSE     = 4'h0;
  localparam logic [3:0]  ADDR_SWTRIG    = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STAT  = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MASK  = 4'hC;

  // Cause register fields
  localparam int          BIT_POR        = 0;
  localparam int          BIT_BROWNOUT   = 1;
  localparam int          BIT_IDLE       = 2;
  localparam int          BIT_SLEEP      = 3;
  localparam int          BIT_WDT_TOUT   = 4;
  localparam int          BIT_SOFT_RST   = 6;
  localparam int          BIT_EXT_PIN    = 7;
  localparam int          BIT_REG_STBY   = 8;
  localparam int          BIT_MISMATCH   = 9;
  localparam logic [9:0]  CAUSE_RESET    = 10'h003;
  localparam logic [9:0]  CAUSE_WR_MASK  = 10'h3DF;
  localparam int          BIT_SOFT_TRIG  = 0;

  // Interrupt status fields
  localparam int          IRQ_EXT        = 0;
  localparam int          IRQ_SOFT       = 1;
  localparam int          IRQ_WDT        = 2;
  localparam int          IRQ_BROWNOUT   = 3;
  localparam int          IRQ_MISMATCH   = 4;
  localparam logic [4:0]  IRQ_RESET      = 5'h00;
  localparam logic [4:0]  IRQ_WR_MASK    = 5'h1F;

  // Synchroniser lanes
  localparam int          SY_EXT_N       = 0;
  localparam int          SY_WDT         = 1;
  localparam int          SY_BROWNOUT    = 2;
  localparam int          SY_MISMATCH    = 3;
  localparam logic [3:0]  SYNC_RESET     = 4'h1;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // Master reset stretch after the last source goes away
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          RST_HOLD_NS    = 100;
  localparam int          HOLD_CYC_INT   = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  HOLD_CYCLES    = 4'(HOLD_CYC_INT);
  localparam logic [3:0]  HOLD_ZERO      = 4'h0;
  localparam logic [3:0]  HOLD_ONE       = 4'h1;
endpackage

// ===== core/src_reset_combiner.sv
module src_reset_combiner
  import src_pkg::*;
(
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_in,
  // Reset sources and power-state events
  input  wire logic                  master_clear_pin_n_in,
  input  wire logic                  watchdog_reset_source_in,
  input  wire logic                  brownout_in,
  input  wire logic                  config_mismatch_in,
  input  wire logic                  sleep_wake_in,
  input  wire logic                  idle_wake_in,
  input  wire logic                  unlock_done_in,
  // AXI4-Lite slave
  input  wire logic [SRC_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                  s_axi_awvalid_in,
  output logic                       s_axi_awready_out,
  input  wire logic [SRC_DATA_W-1:0] s_axi_wdata_in,
  input  wire logic [SRC_STRB_W-1:0] s_axi_wstrb_in,
  input  wire logic                  s_axi_wvalid_in,
  output logic                       s_axi_wready_out,
  output logic [1:0]                 s_axi_bresp_out,
  output logic                       s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  input  wire logic [SRC_ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                  s_axi_arvalid_in,
  output logic                       s_axi_arready_out,
  output logic [SRC_DATA_W-1:0]      s_axi_rdata_out,
  output logic [1:0]                 s_axi_rresp_out,
  output logic                       s_axi_rvalid_out,
  input  wire logic                  s_axi_rready_in,
  // Outputs to the device
  output logic                       system_master_reset_out,
  output logic                       regulator_standby_en_out,
  output logic                       irq_out
);

  logic [SRC_SYNC_W-1:0]  sync_meta;
  logic [SRC_SYNC_W-1:0]  sync_q;
  logic [SRC_SYNC_W-1:0]  sync_prev;
  logic                   ext_active;
  logic                   ext_event;
  logic                   wdt_event;
  logic                   brownout_event;
  logic                   mismatch_event;

  logic [SRC_ADDR_W-1:0]  aw_addr_q;
  logic [SRC_DATA_W-1:0]  w_data_q;
  logic [SRC_STRB_W-1:0]  w_strb_q;
  logic                   do_write;
  logic [SRC_DATA_W-1:0]  wr_mask;
  logic                   wr_cause;
  logic                   wr_irq_stat;
  logic                   wr_irq_mask;
  logic                   wr_swtrig;
  logic                   wr_mapped;

  logic                   soft_reset_pulse;
  logic [3:0]             hold_cnt;
  logic                   any_source;

  logic [SRC_CAUSE_W-1:0] cause_set;
  logic [SRC_CAUSE_W-1:0] cause_q;
  logic [SRC_IRQ_W-1:0]   irq_set;
  logic [SRC_IRQ_W-1:0]   irq_stat_q;
  logic [SRC_IRQ_W-1:0]   irq_mask_q;

  // Detectors run from other oscillators, so the pin, watchdog, brown-out and mismatch sources are synchronised; the wake inputs are not
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sync_meta <= SYNC_RESET;
      sync_q    <= SYNC_RESET;
      sync_prev <= SYNC_RESET;
    end else begin
      sync_meta <= {config_mismatch_in, brownout_in, watchdog_reset_source_in, master_clear_pin_n_in};
      sync_q    <= sync_meta;
      sync_prev <= sync_q;
    end
  end

  assign ext_active     = ~sync_q[SY_EXT_N];
  assign ext_event      = ~sync_q[SY_EXT_N] & sync_prev[SY_EXT_N];
  assign wdt_event      = sync_q[SY_WDT] & ~sync_prev[SY_WDT];
  assign brownout_event = sync_q[SY_BROWNOUT] & ~sync_prev[SY_BROWNOUT];
  assign mismatch_event = sync_q[SY_MISMATCH] & ~sync_prev[SY_MISMATCH];

  // Write channel: address and data taken in either order, held until both are in
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s_axi_awready_out <= 1'b1;
      aw_addr_q         <= '0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      s_axi_awready_out <= 1'b0;
      aw_addr_q         <= s_axi_awaddr_in;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_awready_out <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s_axi_wready_out <= 1'b1;
      w_data_q         <= '0;
      w_strb_q         <= '0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      s_axi_wready_out <= 1'b0;
      w_data_q         <= s_axi_wdata_in;
      w_strb_q         <= s_axi_wstrb_in;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_wready_out <= 1'b1;
    end
  end

  assign do_write = ~s_axi_awready_out & ~s_axi_wready_out & ~s_axi_bvalid_out;

  always_comb begin
    for (int i = 0; i < SRC_STRB_W; i++) begin
      wr_mask[i*8 +: 8] = {8{w_strb_q[i]}};
    end
  end

  assign wr_cause    = do_write && (aw_addr_q == ADDR_CAUSE);
  assign wr_swtrig   = do_write && (aw_addr_q == ADDR_SWTRIG);
  assign wr_irq_stat = do_write && (aw_addr_q == ADDR_IRQ_STAT);
  assign wr_irq_mask = do_write && (aw_addr_q == ADDR_IRQ_MASK);
  assign wr_mapped   = (aw_addr_q == ADDR_CAUSE) || (aw_addr_q == ADDR_SWTRIG) ||
                       (aw_addr_q == ADDR_IRQ_STAT) || (aw_addr_q == ADDR_IRQ_MASK);

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Trigger bit lives one cycle only, so it clears itself; a locked write is dropped
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= wr_swtrig && w_strb_q[0] && w_data_q[BIT_SOFT_TRIG] && unlock_done_in;
    end
  end

  // Master reset: any source, then stretched so the device sees a clean pulse
  assign any_source = ext_active | sync_q[SY_WDT] | sync_q[SY_BROWNOUT] | sync_q[SY_MISMATCH] |
                      soft_reset_pulse;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      system_master_reset_out <= 1'b1;
      hold_cnt                <= HOLD_CYCLES;
    end else if (any_source) begin
      system_master_reset_out <= 1'b1;
      hold_cnt                <= HOLD_CYCLES;
    end else if (hold_cnt != HOLD_ZERO) begin
      system_master_reset_out <= 1'b1;
      hold_cnt                <= hold_cnt - HOLD_ONE;
    end else begin
      system_master_reset_out <= 1'b0;
    end
  end

  // Cause flags: this block is not reset by the master reset it drives, so flags survive it
  always_comb begin
    cause_set            = '0;
    cause_set[BIT_MISMATCH] = mismatch_event;
    cause_set[BIT_EXT_PIN]  = ext_event;
    cause_set[BIT_SOFT_RST] = soft_reset_pulse;
    cause_set[BIT_WDT_TOUT] = wdt_event;
    cause_set[BIT_SLEEP]    = sleep_wake_in;
    cause_set[BIT_IDLE]     = idle_wake_in;
    cause_set[BIT_BROWNOUT] = brownout_event;
  end

  // Power-on flag is set by the block reset or by a software write of one; no source event sets it
  src_sticky_reg #(
    .WIDTH     (SRC_CAUSE_W),
    .RESET_VAL (CAUSE_RESET),
    .W1C       (1'b0)
  ) u_cause (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .set_in     (cause_set),
    .wr_en_in   (wr_cause),
    .wr_mask_in (wr_mask[SRC_CAUSE_W-1:0] & CAUSE_WR_MASK),
    .wr_data_in (w_data_q[SRC_CAUSE_W-1:0]),
    .value_out  (cause_q)
  );

  always_comb begin
    irq_set           = '0;
    irq_set[IRQ_EXT]  = ext_event;
    irq_set[IRQ_SOFT] = soft_reset_pulse;
    irq_set[IRQ_WDT]  = wdt_event;
    irq_set[IRQ_BROWNOUT] = brownout_event;
    irq_set[IRQ_MISMATCH] = mismatch_event;
  end

  src_sticky_reg #(
    .WIDTH     (SRC_IRQ_W),
    .RESET_VAL (IRQ_RESET),
    .W1C       (1'b1)
  ) u_irq_stat (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .set_in     (irq_set),
    .wr_en_in   (wr_irq_stat),
    .wr_mask_in (wr_mask[SRC_IRQ_W-1:0] & IRQ_WR_MASK),
    .wr_data_in (w_data_q[SRC_IRQ_W-1:0]),
    .value_out  (irq_stat_q)
  );

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      irq_mask_q <= IRQ_RESET;
    end else if (wr_irq_mask && w_strb_q[0]) begin
      irq_mask_q <= w_data_q[SRC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      regulator_standby_en_out <= 1'b0;
    end else begin
      regulator_standby_en_out <= cause_q[BIT_REG_STBY];
    end
  end

  // Read channel: data sampled at the address handshake, answered one edge later
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rresp_out   <= RESP_OKAY;
      s_axi_rdata_out   <= '0;
      case (s_axi_araddr_in)
        ADDR_CAUSE: begin
          s_axi_rdata_out[SRC_CAUSE_W-1:0] <= cause_q;
        end
        ADDR_SWTRIG: begin
          s_axi_rdata_out <= '0;
        end
        ADDR_IRQ_STAT: begin
          s_axi_rdata_out[SRC_IRQ_W-1:0] <= irq_stat_q;
        end
        ADDR_IRQ_MASK: begin
          s_axi_rdata_out[SRC_IRQ_W-1:0] <= irq_mask_q;
        end
        default: begin
          s_axi_rresp_out <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
    end
  end

endmodule

// ===== core/src_sticky_reg.sv
// Flag vector: hardware set wins over a software write in the same cycle
module src_sticky_reg #(
  parameter int                 WIDTH     = 8,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0,
  parameter bit                 W1C       = 1'b0
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic             wr_en_in,
  input  wire logic [WIDTH-1:0] wr_mask_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic      [WIDTH-1:0] value_out
);
  logic [WIDTH-1:0] next_value;

  always_comb begin
    next_value = value_out;
    if (wr_en_in) begin
      if (W1C) begin
        next_value = value_out & ~(wr_data_in & wr_mask_in);
      end else begin
        next_value = (value_out & ~wr_mask_in) | (wr_data_in & wr_mask_in);
      end
    end
    next_value = next_value | set_in;
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      value_out <= RESET_VAL;
    end else begin
      value_out <= next_value;
    end
  end
endmodule

// ===== testbench/src_rc_asserts.sv
module src_rc_asserts
  import src_pkg::*;
(
  input wire logic                  sys_clk_in,
  input wire logic                  reset_in,
  input wire logic                  master_clear_pin_n_in,
  input wire logic                  watchdog_reset_source_in,
  input wire logic                  brownout_in,
  input wire logic                  config_mismatch_in,
  input wire logic                  unlock_done_in,
  input wire logic [SRC_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic                  s_axi_awvalid_in,
  input wire logic                  s_axi_awready_out,
  input wire logic [SRC_DATA_W-1:0] s_axi_wdata_in,
  input wire logic [SRC_STRB_W-1:0] s_axi_wstrb_in,
  input wire logic                  s_axi_wvalid_in,
  input wire logic                  s_axi_wready_out,
  input wire logic [SRC_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic                  s_axi_arvalid_in,
  input wire logic                  s_axi_arready_out,
  input wire logic [SRC_DATA_W-1:0] s_axi_rdata_out,
  input wire logic                  s_axi_rvalid_out,
  input wire logic                  system_master_reset_out,
  input wire logic                  regulator_standby_en_out,
  input wire logic                  irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0]            quiet_cnt;
  logic [SRC_ADDR_W-1:0] rd_addr;
  wire logic             src_on = !master_clear_pin_n_in || watchdog_reset_source_in || brownout_in
                                  || config_mismatch_in;
  // A write may launch a soft reset, so it restarts the quiet count too
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || src_on || s_axi_awvalid_in) begin
      quiet_cnt <= 5'h00;
    end else if (quiet_cnt != 5'h1F) begin
      quiet_cnt <= quiet_cnt + 5'h01;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      rd_addr <= s_axi_araddr_in;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  sequence sw_write;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_awaddr_in == ADDR_SWTRIG && s_axi_wvalid_in
      && s_axi_wready_out && s_axi_wdata_in[0] && s_axi_wstrb_in[0] && unlock_done_in;
  endsequence
  sequence src_held;
    src_on [*4];
  endsequence
  chk_reset_merge: assert property (disable iff (1'b0) reset_in |=> system_master_reset_out)
    else $error("master reset low during block reset");
  chk_source_reset: assert property (src_held |=> system_master_reset_out)
    else $error("held source did not raise master reset");
  chk_stretch_min: assert property ($fell(system_master_reset_out) |-> quiet_cnt >= 5'h0A)
    else $error("master reset released too early");
  chk_release_bound: assert property (quiet_cnt == 5'h18 |-> !system_master_reset_out)
    else $error("master reset stuck high");
  chk_soft_reset: assert property (sw_write |-> ##[1:8] system_master_reset_out)
    else $error("soft trigger did not reset");
  chk_cause_zeros: assert property (s_axi_rvalid_out && rd_addr == ADDR_CAUSE
    |-> s_axi_rdata_out[31:10] == 22'h0 && !s_axi_rdata_out[5])
    else $error("unimplemented cause bits not zero");
  chk_trig_zero: assert property (s_axi_rvalid_out && rd_addr == ADDR_SWTRIG |-> s_axi_rdata_out == 32'h0)
    else $error("trigger register reads nonzero");
  chk_reset_outs: assert property (disable iff (1'b0) reset_in |=> !regulator_standby_en_out && !irq_out)
    else $error("regulator or irq high after reset");
endmodule

bind src_reset_combiner src_rc_asserts chk (.sys_clk_in, .reset_in, .master_clear_pin_n_in,
  .watchdog_reset_source_in, .brownout_in, .config_mismatch_in, .unlock_done_in, .s_axi_awaddr_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
  .s_axi_rvalid_out, .system_master_reset_out, .regulator_standby_en_out, .irq_out);

// ===== testbench/src_reset_combiner_test.sv
module src_reset_combiner_test
  import src_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_in = 1'b0, reset_in = 1'b1, unlock_done_in = 1'b0, go = 1'b0;
  logic [2:0]  sel = 3'h0;
  logic        pin_n, wdt, brown, mism, slp, idl;
  logic [3:0]  s_axi_awaddr_in = 4'h0, s_axi_araddr_in = 4'h0, s_axi_wstrb_in = 4'h0;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, exp;
  logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic        system_master_reset_out, regulator_standby_en_out, irq_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  int          n_errors = 0, checks_done = 0;
  int          cb[5] = '{BIT_EXT_PIN, BIT_SOFT_RST, BIT_WDT_TOUT, BIT_BROWNOUT, BIT_MISMATCH};
  logic [2:0]  sl[5] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3};
  always #5 sys_clk_in = ~sys_clk_in;
  src_source_model src (.sys_clk_in, .go_in(go), .sel_in(sel), .master_clear_pin_n_out(pin_n),
    .watchdog_out(wdt), .brownout_out(brown), .mismatch_out(mism), .sleep_wake_out(slp), .idle_wake_out(idl));
  src_reset_combiner dut (.sys_clk_in, .reset_in, .unlock_done_in, .master_clear_pin_n_in(pin_n),
    .watchdog_reset_source_in(wdt), .brownout_in(brown), .config_mismatch_in(mism), .sleep_wake_in(slp),
    .idle_wake_in(idl), .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
    .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
    .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .system_master_reset_out,
    .regulator_standby_en_out, .irq_out);
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= 4'hF;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (!ad && s_axi_awready_out) begin
        ad = 1'b1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (!wd && s_axi_wready_out) begin
        wd = 1'b1;
        s_axi_wvalid_in <= 1'b0;
      end
    end while (!(ad && wd));
    do @(posedge sys_clk_in); while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
    chk(s_axi_bresp_out, r);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do @(posedge sys_clk_in); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge sys_clk_in); while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 1'b0;
    chk(s_axi_rdata_out, d);
    chk(s_axi_rresp_out, r);
  endtask
  task automatic wait_rst(input logic v);
    repeat (200) if (system_master_reset_out !== v) @(posedge sys_clk_in);
    chk(system_master_reset_out, v);
  endtask
  task automatic fire(input logic [2:0] s);
    sel <= s;
    go <= 1'b1;
    @(posedge sys_clk_in);
    go <= 1'b0;
    // Let an edge pass so a following call never drives go twice in one step
    @(posedge sys_clk_in);
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    wait_rst(1'b0);
    rd(ADDR_CAUSE, 32'h3, RESP_OKAY);
    rd(ADDR_SWTRIG, 32'h0, RESP_OKAY);
    rd(4'h2, 32'h0, RESP_SLVERR);
    wr(ADDR_CAUSE, 32'hFFFFFD20, RESP_OKAY);
    rd(ADDR_CAUSE, 32'h100, RESP_OKAY);
    chk(regulator_standby_en_out, 1'b1);
    wr(ADDR_CAUSE, 32'h0, RESP_OKAY);
    wr(ADDR_IRQ_MASK, 32'h1F, RESP_OKAY);
    // Locked trigger and a zero write must both be ignored
    wr(ADDR_SWTRIG, 32'h1, RESP_OKAY);
    repeat (10) @(posedge sys_clk_in);
    chk(system_master_reset_out, 1'b0);
    unlock_done_in <= 1'b1;
    wr(ADDR_SWTRIG, 32'h0, RESP_OKAY);
    repeat (10) @(posedge sys_clk_in);
    chk(system_master_reset_out, 1'b0);
    exp = 32'h0;
    for (int i = 0; i < 5; i++) begin
      if (i == 1) wr(ADDR_SWTRIG, 32'h1, RESP_OKAY);
      else fire(sl[i]);
      wait_rst(1'b1);
      wait_rst(1'b0);
      exp[cb[i]] = 1'b1;
      rd(ADDR_CAUSE, exp, RESP_OKAY);
      rd(ADDR_IRQ_STAT, 32'h1 << i, RESP_OKAY);
      chk(irq_out, 1'b1);
      wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
      repeat (3) @(posedge sys_clk_in);
      chk(irq_out, 1'b0);
      wr(ADDR_IRQ_STAT, 32'h1F, RESP_OKAY);
      wr(ADDR_IRQ_MASK, 32'h1F, RESP_OKAY);
      repeat (3) @(posedge sys_clk_in);
      chk(irq_out, 1'b0);
    end
    fire(3'h4);
    fire(3'h5);
    repeat (6) @(posedge sys_clk_in);
    rd(ADDR_CAUSE, exp | 32'hC, RESP_OKAY);
    chk(system_master_reset_out, 1'b0);
    end_of_test();
  end
  // Whole sequence takes well under two thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_errors++;
    end_of_test();
  end
endmodule

// ===== testbench/src_source_model.sv
module src_source_model (
  input  wire logic       sys_clk_in,
  input  wire logic       go_in,
  input  wire logic [2:0] sel_in,
  output logic            master_clear_pin_n_out,
  output logic            watchdog_out,
  output logic            brownout_out,
  output logic            mismatch_out,
  output logic            sleep_wake_out,
  output logic            idle_wake_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] len = 4'h0;
  logic [2:0] sel = 3'h0;
  always @(posedge sys_clk_in) begin
    if (go_in) begin
      sel <= sel_in;
      len <= 4'h8;
    end else if (len != 4'h0) begin
      len <= len - 4'h1;
    end
  end
  // Source levels last eight cycles so the synchroniser cannot miss them; the two wake outputs pulse for one cycle
  assign master_clear_pin_n_out = !(len != 4'h0 && sel == 3'h0);
  assign watchdog_out = len != 4'h0 && sel == 3'h1;
  assign brownout_out = len != 4'h0 && sel == 3'h2;
  assign mismatch_out = len != 4'h0 && sel == 3'h3;
  assign sleep_wake_out = len == 4'h8 && sel == 3'h4;
  assign idle_wake_out = len == 4'h8 && sel == 3'h5;
endmodule
